// ==== rlel_cfg.svh ====
// Constants of the relay and logger block.
// Included by bare name.
`ifndef RLEL_CFG_SVH
`define RLEL_CFG_SVH
// Clock rate and the one-second tick derived from it.
`define RLEL_CLK_HZ      200000000
`define RLEL_TICK_S      1
`define RLEL_TICK_CYC    (`RLEL_CLK_HZ * `RLEL_TICK_S)
`define RLEL_HOUR_S      12'he0f
// Counts of the block.
`define RLEL_NREL        3
`define RLEL_NLIM        16
`define RLEL_NDIN        4
`define RLEL_MAX_ITEMS   6'h37
`define RLEL_LOG_CAP     17'h18b33
`define RLEL_WAVE_PTS    10'h3c0
`define RLEL_WAVES_WYE   3'h6
`define RLEL_WAVES_DELTA 3'h5
// Capture limit values that mean disabled.
`define RLEL_WLIM_MIN    14'h0000
`define RLEL_WLIM_MAX    14'h270f
// Register byte offsets.
`define RLEL_OFF_CTRL    8'h00
`define RLEL_OFF_IVL     8'h04
`define RLEL_OFF_TIME    8'h08
`define RLEL_OFF_STAT    8'h0c
`define RLEL_OFF_LOGCNT  8'h10
`define RLEL_OFF_TRIP    8'h14
`define RLEL_OFF_SNAP    8'h18
`define RLEL_OFF_WLIM0   8'h1c
`define RLEL_OFF_RLINK0  8'h30
`define RLEL_OFF_RDLY0   8'h34
`define RLEL_OFF_RCMD    8'h48
`define RLEL_RSTRIDE     8'h08
// Control register fields.
`define RLEL_CTRL_LOG    0
`define RLEL_CTRL_SYNC   1
`define RLEL_CTRL_WYE    2
`define RLEL_CTRL_EXT    3
`define RLEL_CTRL_ITEMS  8
`define RLEL_CTRL_WCNT   16
// Reset values.
`define RLEL_RST_CTRL    32'h0001_3704
`define RLEL_RST_IVL     16'h0384
`define RLEL_RST_WLIM    16'h0000
`endif

// ==== rlel_pkg.sv ====
// Types shared by the relay and logger block.
// Assumes rlel_cfg.svh is compiled alongside.
package rlel_pkg;
  // Settings of one relay channel.
  typedef struct packed {
    logic [15:0] link;
    logic [3:0]  hi_idx;
    logic [3:0]  lo_idx;
    logic        and_mode;
    logic        hyst;
    logic        comp_en;
    logic        neg;
    logic [15:0] set_dly;
    logic [15:0] rst_dly;
  } rlel_relay_cfg_t;
  // One waveform capture limit.
  typedef struct packed {
    logic        snap;
    logic        above;
    logic [13:0] value;
  } rlel_wlim_t;
  // Reasons for a historical record.
  typedef struct packed {
    logic interval;
    logic lim_up;
    logic lim_down;
    logic wave;
    logic io;
  } rlel_cause_t;
  // Waveform capture sequencer states.
  typedef enum {WV_IDLE, WV_CAP} rlel_wave_st_t;
endpackage

// ==== rlel_relay.sv ====
// One relay channel: combiner, hysteresis, set and reset delays, override, polarity.
// Assumes limit flags on the same clock and a one-cycle second tick.
`timescale 1ns/1ps
`include "rlel_cfg.svh"
module rlel_relay (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Timing and inputs.
  input  wire logic                     tick,
  input  wire logic [`RLEL_NLIM-1:0]    lim,
  input  wire rlel_pkg::rlel_relay_cfg_t cfg,
  input  wire logic                     cmd_force,
  input  wire logic                     cmd_val,
  // Relay state and contacts.
  output logic                          set_q,
  output logic                          com_no_q,
  output logic                          com_nc_q
);
  logic        cond;
  logic [15:0] cnt_q;
  logic [15:0] dly;

  // Wanted state from the linked limits.
  always_comb begin
    if (cfg.hyst) begin
      cond = set_q ? lim[cfg.lo_idx] : lim[cfg.hi_idx]; // [R6] [R7]
    end else if (cfg.and_mode) begin
      cond = (|cfg.link) & (&(lim | ~cfg.link)); // [R4]
    end else begin
      cond = |(lim & cfg.link); // [R5]
    end
    dly = set_q ? cfg.rst_dly : cfg.set_dly;
  end

  // Delay timing and state change; a reverted condition cancels the wait.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      set_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (cfg.comp_en && cmd_force) begin
      set_q <= cmd_val; // [R3]
      cnt_q <= 16'h0000;
    end else if (cond == set_q) begin
      cnt_q <= 16'h0000; // [R23]
    end else if (cnt_q >= dly) begin
      set_q <= cond; // [R1]
      cnt_q <= 16'h0000;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001; // [R24]
    end
  end

  // Contact continuity follows state and polarity.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      com_no_q <= 1'b0;
      com_nc_q <= 1'b1;
    end else begin
      com_no_q <= set_q ^ cfg.neg; // [R8] [R9]
      com_nc_q <= ~(set_q ^ cfg.neg); // [R8] [R9]
    end
  end
endmodule

// ==== rlel_wave.sv ====
// Waveform capture trigger from two-cycle RMS values against four shared limits.
// Assumes RMS values and capture-done pulses from the measurement engine on this clock.
`timescale 1ns/1ps
`include "rlel_cfg.svh"
module rlel_wave (
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // RMS values, voltages 0..1 and currents 2..3 are the limits.
  input  wire logic                   rms_valid,
  input  wire logic [2:0][13:0]       rms_v,
  input  wire logic [2:0][13:0]       rms_i,
  input  wire rlel_pkg::rlel_wlim_t [3:0] wlim,
  // Mode settings.
  input  wire logic                   wye,
  input  wire logic                   ext,
  input  wire logic [7:0]             cnt_max,
  // Capture handshake.
  input  wire logic                   cap_done,
  output logic                        cap_start_q,
  output logic                        snap_q,
  output logic                        busy
);
  logic [3:0]           exc_q;
  logic [3:0]           exc_d;
  logic [7:0]           taken_q;
  rlel_pkg::rlel_wave_st_t st_q;

  // True when a value trips a limit; a disabled limit never trips.
  function automatic logic trips(input logic [13:0] v, input rlel_pkg::rlel_wlim_t l);
    logic off;
    off = (l.value == `RLEL_WLIM_MIN && !l.above) || (l.value == `RLEL_WLIM_MAX && l.above);
    trips = !off && (l.above ? (v > l.value) : (v < l.value)); // [R19]
  endfunction

  // Shared limits over all channels; delta wiring uses two voltages.
  always_comb begin
    exc_d = 4'h0;
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 3; c++) begin
        if (wye || c < 2) begin
          exc_d[k] = exc_d[k] | trips(rms_v[c], wlim[k]); // [R18]
        end
        exc_d[k+2] = exc_d[k+2] | trips(rms_i[c], wlim[k+2]); // [R18]
      end
    end
  end

  // Limit flags update on each new RMS result.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exc_q <= 4'h0;
      snap_q <= 1'b0;
    end else begin
      snap_q <= 1'b0;
      if (rms_valid) begin
        exc_q <= exc_d; // [R17]
        snap_q <= |(exc_d & ~exc_q & {wlim[3].snap, wlim[2].snap, wlim[1].snap, wlim[0].snap}); // [R20]
      end
    end
  end

  assign busy = (st_q == rlel_pkg::WV_CAP);

  // Capture sequencer for normal and extended modes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= rlel_pkg::WV_IDLE;
      taken_q <= 8'h00;
      cap_start_q <= 1'b0;
    end else begin
      cap_start_q <= 1'b0;
      case (st_q)
        rlel_pkg::WV_IDLE: begin
          if (rms_valid && |(exc_d & ~exc_q) && cnt_max != 8'h00) begin
            st_q <= rlel_pkg::WV_CAP; // [R17]
            taken_q <= 8'h00;
            cap_start_q <= 1'b1;
          end
        end
        rlel_pkg::WV_CAP: begin
          if (cap_done) begin
            taken_q <= taken_q + 8'h01;
            if (taken_q + 8'h01 >= cnt_max) begin
              st_q <= rlel_pkg::WV_IDLE; // [R21] [R22]
            end else if (ext || |exc_q) begin
              cap_start_q <= 1'b1; // [R21] [R22]
            end else begin
              st_q <= rlel_pkg::WV_IDLE; // [R21]
            end
          end
        end
        default: begin
          st_q <= rlel_pkg::WV_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== rlel_top.sv ====
// Relay limit logic and event logger with an AHB-Lite register slave.
// Assumes a measurement engine on clk, digital inputs from pins, one AHB-Lite master.
// Contract
// [R1] Relay changes only after set/reset delay
// [R2] Three independent relay channels
// [R3] Computer control enable gates host commands
// [R4] AND needs every linked limit exceeded
// [R5] OR needs any linked limit exceeded
// [R6] Hysteresis turns on above higher limit
// [R7] Hysteresis stays on until below lower
// [R8] Positive: reset to NC, set to NO
// [R9] Negative: reset to NO, set to NC
// [R10] Record has timestamp plus up to 55 items
// [R11] Record on interval, limits, wave, I/O change
// [R12] Limit snapshots need selection and trip enabled
// [R13] Log holds 101171 values before full
// [R14] Unaligned: record now, then every interval
// [R15] Aligned: boundaries from hour top, hour forces
// [R16] Wave record: timestamp, 6 or 5 x960
// [R17] Capture starts on two-cycle RMS crossing
// [R18] Two shared voltage, two current limits
// [R19] 0000 below or 9999 above disables
// [R20] Capture limit may also request snapshot
// [R21] Normal mode stops on count or clear
// [R22] Extended mode always takes full count
// [R23] Reverted condition cancels pending relay change
// [R24] Second counters advance on one-second tick
`timescale 1ns/1ps
`include "rlel_cfg.svh"
module rlel_top #(
  parameter int TICK_CYC = `RLEL_TICK_CYC
) (
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // AHB-Lite slave.
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // Measurement engine.
  input  wire logic [`RLEL_NLIM-1:0]  lim_exc,
  input  wire logic                   rms_valid,
  input  wire logic [2:0][13:0]       rms_v,
  input  wire logic [2:0][13:0]       rms_i,
  input  wire logic                   cap_done,
  // Digital input pins.
  input  wire logic [`RLEL_NDIN-1:0]  din,
  // Relay outputs.
  output logic [`RLEL_NREL-1:0]       relay_set,
  output logic [`RLEL_NREL-1:0]       relay_com_no,
  output logic [`RLEL_NREL-1:0]       relay_com_nc,
  // Waveform capture request.
  output logic                        cap_start,
  output logic [2:0]                  cap_waves,
  output logic [9:0]                  cap_points,
  output logic [31:0]                 cap_stamp,
  // Historical record request.
  output logic                        hist_req,
  output rlel_pkg::rlel_cause_t       hist_cause,
  output logic [31:0]                 hist_stamp,
  output logic [5:0]                  hist_items,
  output logic                        log_full
);
  logic [31:0]                 ctrl_q;
  logic [15:0]                 ivl_q;
  logic [`RLEL_NLIM-1:0]       trip_q;
  logic [`RLEL_NLIM-1:0]       snap_q;
  rlel_pkg::rlel_wlim_t [3:0]  wlim_q;
  logic [31:0]                 rlink_q [`RLEL_NREL];
  logic [31:0]                 rdly_q  [`RLEL_NREL];
  logic [2:0]                  cmd_force_q;
  logic [2:0]                  cmd_val_q;
  logic                        wr_q;
  logic [7:0]                  wa_q;
  logic [31:0]                 tick_cnt_q;
  logic                        tick;
  logic [11:0]                 soh_q;
  logic [19:0]                 hour_q;
  logic                        hour_wrap;
  logic [15:0]                 icnt_q;
  logic                        log_en_q;
  logic                        start;
  logic                        timed;
  logic [`RLEL_NLIM-1:0]       lim_prev_q;
  logic [`RLEL_NDIN-1:0]       din_s1_q;
  logic [`RLEL_NDIN-1:0]       din_s2_q;
  logic [`RLEL_NDIN-1:0]       din_prev_q;
  logic [`RLEL_NREL-1:0]       rel_prev_q;
  logic [16:0]                 log_cnt_q;
  logic [5:0]                  items;
  logic                        wv_start;
  logic                        wv_snap;
  logic                        wv_busy;
  logic                        clr_cnt;
  rlel_pkg::rlel_cause_t       cause;
  logic [`RLEL_NLIM-1:0]       lim_sel;

  // Relay channel addressed by a byte offset, or 3 for none.
  function automatic logic [1:0] relay_of(input logic [7:0] a, input logic [7:0] base);
    relay_of = 2'h3;
    for (int r = 0; r < `RLEL_NREL; r++) begin
      if (a == base + 8'(r) * `RLEL_RSTRIDE) begin
        relay_of = 2'(r);
      end
    end
  endfunction

  // Zero-wait slave with an always OKAY response.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture for writes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else if (hready) begin
      wr_q <= hsel && htrans[1] && hwrite;
      wa_q <= haddr[7:0];
    end
  end

  assign clr_cnt = wr_q && (wa_q == `RLEL_OFF_LOGCNT);

  // Register writes in the data phase; the command register is a one-cycle strobe.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `RLEL_RST_CTRL;
      ivl_q <= `RLEL_RST_IVL;
      trip_q <= '0;
      snap_q <= '0;
      wlim_q <= {4{`RLEL_RST_WLIM}};
      cmd_force_q <= 3'h0;
      cmd_val_q <= 3'h0;
      for (int r = 0; r < `RLEL_NREL; r++) begin
        rlink_q[r] <= 32'h0000_0000;
        rdly_q[r] <= 32'h0000_0000;
      end
    end else begin
      cmd_force_q <= 3'h0;
      if (wr_q) begin
        case (wa_q)
          `RLEL_OFF_CTRL: ctrl_q <= hwdata;
          `RLEL_OFF_IVL:  ivl_q <= hwdata[15:0];
          `RLEL_OFF_TRIP: trip_q <= hwdata[`RLEL_NLIM-1:0];
          `RLEL_OFF_SNAP: snap_q <= hwdata[`RLEL_NLIM-1:0];
          `RLEL_OFF_RCMD: begin
            cmd_force_q <= hwdata[2:0];
            cmd_val_q <= hwdata[6:4];
          end
          default: begin
            for (int k = 0; k < 4; k++) begin
              if (wa_q == `RLEL_OFF_WLIM0 + 8'(4 * k)) begin
                wlim_q[k] <= hwdata[15:0];
              end
            end
            if (relay_of(wa_q, `RLEL_OFF_RLINK0) != 2'h3) begin
              rlink_q[relay_of(wa_q, `RLEL_OFF_RLINK0)] <= hwdata;
            end
            if (relay_of(wa_q, `RLEL_OFF_RDLY0) != 2'h3) begin
              rdly_q[relay_of(wa_q, `RLEL_OFF_RDLY0)] <= hwdata;
            end
          end
        endcase
      end
    end
  end

  // Read data registered in the address phase; unmapped offsets read zero.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= 32'h0000_0000;
      case (haddr[7:0])
        `RLEL_OFF_CTRL:   hrdata <= ctrl_q;
        `RLEL_OFF_IVL:    hrdata <= {16'h0000, ivl_q};
        `RLEL_OFF_TIME:   hrdata <= {hour_q, soh_q};
        `RLEL_OFF_STAT:   hrdata <= {27'h0, wv_busy, log_full, relay_set};
        `RLEL_OFF_LOGCNT: hrdata <= {15'h0000, log_cnt_q};
        `RLEL_OFF_TRIP:   hrdata <= {{(32-`RLEL_NLIM){1'b0}}, trip_q};
        `RLEL_OFF_SNAP:   hrdata <= {{(32-`RLEL_NLIM){1'b0}}, snap_q};
        default: begin
          for (int k = 0; k < 4; k++) begin
            if (haddr[7:0] == `RLEL_OFF_WLIM0 + 8'(4 * k)) begin
              hrdata <= {16'h0000, wlim_q[k]};
            end
          end
          if (relay_of(haddr[7:0], `RLEL_OFF_RLINK0) != 2'h3) begin
            hrdata <= rlink_q[relay_of(haddr[7:0], `RLEL_OFF_RLINK0)];
          end
          if (relay_of(haddr[7:0], `RLEL_OFF_RDLY0) != 2'h3) begin
            hrdata <= rdly_q[relay_of(haddr[7:0], `RLEL_OFF_RDLY0)];
          end
        end
      endcase
    end
  end

  // One-second tick divider.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  assign tick      = (tick_cnt_q == 32'(TICK_CYC - 1)); // [R24]
  assign hour_wrap = tick && (soh_q == `RLEL_HOUR_S);

  // Meter clock as hours and seconds of the hour; software may set it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      soh_q <= 12'h000;
      hour_q <= 20'h00000;
    end else if (wr_q && wa_q == `RLEL_OFF_TIME) begin
      soh_q <= hwdata[11:0];
      hour_q <= hwdata[31:12];
    end else if (hour_wrap) begin
      soh_q <= 12'h000;
      hour_q <= hour_q + 20'h00001;
    end else if (tick) begin
      soh_q <= soh_q + 12'h001;
    end
  end

  // Relay channels.
  generate
    for (genvar r = 0; r < `RLEL_NREL; r++) begin : g_rel
      rlel_pkg::rlel_relay_cfg_t cfg;
      assign cfg = {rlink_q[r][15:0], rlink_q[r][19:16], rlink_q[r][23:20], rlink_q[r][24],
                    rlink_q[r][25], rlink_q[r][26], rlink_q[r][27],
                    rdly_q[r][15:0], rdly_q[r][31:16]};
      rlel_relay u_rel ( // [R2]
        .clk       (clk),
        .resetn    (resetn),
        .tick      (tick),
        .lim       (lim_exc),
        .cfg       (cfg),
        .cmd_force (cmd_force_q[r]),
        .cmd_val   (cmd_val_q[r]),
        .set_q     (relay_set[r]),
        .com_no_q  (relay_com_no[r]),
        .com_nc_q  (relay_com_nc[r])
      );
    end
  endgenerate

  // Waveform trigger.
  rlel_wave u_wave (
    .clk         (clk),
    .resetn      (resetn),
    .rms_valid   (rms_valid),
    .rms_v       (rms_v),
    .rms_i       (rms_i),
    .wlim        (wlim_q),
    .wye         (ctrl_q[`RLEL_CTRL_WYE]),
    .ext         (ctrl_q[`RLEL_CTRL_EXT]),
    .cnt_max     (ctrl_q[`RLEL_CTRL_WCNT +: 8]),
    .cap_done    (cap_done),
    .cap_start_q (wv_start),
    .snap_q      (wv_snap),
    .busy        (wv_busy)
  );
  assign cap_start = wv_start;

  // Stamp and shape of each waveform record.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cap_stamp <= 32'h0000_0000;
      cap_waves <= `RLEL_WAVES_WYE;
      cap_points <= `RLEL_WAVE_PTS;
    end else if (wv_start) begin
      cap_stamp <= {hour_q, soh_q}; // [R16]
      cap_waves <= ctrl_q[`RLEL_CTRL_WYE] ? `RLEL_WAVES_WYE : `RLEL_WAVES_DELTA; // [R16]
      cap_points <= `RLEL_WAVE_PTS;
    end
  end

  // Pin synchroniser and edge history for event detection.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
      din_prev_q <= '0;
      lim_prev_q <= '0;
      rel_prev_q <= '0;
      log_en_q <= 1'b0;
    end else begin
      din_s1_q <= din;
      din_s2_q <= din_s1_q;
      din_prev_q <= din_s2_q;
      lim_prev_q <= lim_exc;
      rel_prev_q <= relay_set;
      log_en_q <= ctrl_q[`RLEL_CTRL_LOG];
    end
  end

  assign start   = ctrl_q[`RLEL_CTRL_LOG] && !log_en_q;
  assign lim_sel = snap_q & trip_q; // [R12]
  assign items   = (ctrl_q[`RLEL_CTRL_ITEMS +: 6] > `RLEL_MAX_ITEMS) ? `RLEL_MAX_ITEMS
                   : ctrl_q[`RLEL_CTRL_ITEMS +: 6]; // [R10]

  // Interval scheduler with optional alignment to the hour.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      icnt_q <= 16'h0000;
      timed <= 1'b0;
    end else begin
      timed <= 1'b0;
      if (start) begin
        timed <= 1'b1; // [R14] [R15]
        if (ctrl_q[`RLEL_CTRL_SYNC] && ivl_q != 16'h0000) begin
          icnt_q <= ivl_q - ({4'h0, soh_q} % ivl_q); // [R15]
        end else begin
          icnt_q <= ivl_q; // [R14]
        end
      end else if (tick && log_en_q && ivl_q != 16'h0000) begin
        if (ctrl_q[`RLEL_CTRL_SYNC] && hour_wrap) begin
          timed <= 1'b1; // [R15]
          icnt_q <= ivl_q;
        end else if (icnt_q <= 16'h0001) begin
          timed <= 1'b1; // [R14]
          icnt_q <= ivl_q;
        end else begin
          icnt_q <= icnt_q - 16'h0001; // [R24]
        end
      end
    end
  end

  // Reasons for a record in this cycle.
  always_comb begin
    cause.interval = timed;
    cause.lim_up   = |(lim_exc & ~lim_prev_q & lim_sel); // [R11] [R12]
    cause.lim_down = |(~lim_exc & lim_prev_q & lim_sel); // [R11] [R12]
    cause.wave     = wv_start | wv_snap; // [R11] [R20]
    cause.io       = |(relay_set ^ rel_prev_q) | |(din_s2_q ^ din_prev_q); // [R11]
  end

  // Record request, store fill count and full flag; a record in the clearing cycle counts.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hist_req <= 1'b0;
      hist_cause <= '0;
      hist_stamp <= 32'h0000_0000;
      hist_items <= 6'h00;
      log_cnt_q <= 17'h00000;
      log_full <= 1'b0;
    end else begin
      hist_req <= 1'b0;
      if (clr_cnt) begin
        log_cnt_q <= 17'h00000;
        log_full <= 1'b0;
      end
      if (log_en_q && |cause) begin
        if ((clr_cnt ? 18'h0 : {1'b0, log_cnt_q}) + 18'(items) <= 18'(`RLEL_LOG_CAP)) begin
          hist_req <= 1'b1; // [R11]
          hist_cause <= cause;
          hist_stamp <= {hour_q, soh_q}; // [R10]
          hist_items <= items;
          log_cnt_q <= (clr_cnt ? 17'h00000 : log_cnt_q) + 17'(items); // [R13]
        end else begin
          log_full <= 1'b1; // [R13]
        end
      end
    end
  end
endmodule

// ==== rlel_chk.sv ====
// Checker on the top ports of the relay and logger block.
// Assumes it is bound into rlel_top and sees its clock and reset.
`timescale 1ns/1ps
module rlel_chk (
  // Clock and reset.
  input logic       clk,
  input logic       resetn,
  // Bus answer.
  input logic       hreadyout,
  input logic       hresp,
  // Engine side.
  input logic       rms_valid,
  input logic       cap_done,
  input logic       cap_start,
  input logic [2:0] cap_waves,
  input logic [9:0] cap_points,
  // Relays.
  input logic [2:0] relay_set,
  input logic [2:0] relay_com_no,
  input logic [2:0] relay_com_nc,
  // History.
  input logic       hist_req,
  input logic [4:0] hist_cause,
  input logic [5:0] hist_items,
  input logic       log_full
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Each contact pair closes exactly one side.
  property p_contact; relay_com_nc == ~relay_com_no; endproperty
  a_contact: assert property (p_contact) else $error("contacts both open or both shut");
  // The slave is always ready and answers OKAY.
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus answer not ready or not okay");
  // Capture points are fixed at 960; waves are six or five.
  property p_wave; cap_points == 10'h3c0 && (cap_waves == 3'h6 || cap_waves == 3'h5); endproperty
  a_wave: assert property (p_wave) else $error("capture geometry wrong");
  // A capture request lasts one cycle.
  property p_pulse; cap_start |=> !cap_start; endproperty
  a_pulse: assert property (p_pulse) else $error("capture request too long");
  // A capture follows new RMS values or a finished capture.
  property p_cause; cap_start |-> $past(rms_valid || cap_done); endproperty
  a_cause: assert property (p_cause) else $error("capture without cause");
  // A record never holds more than 55 items.
  property p_items; hist_items <= 6'h37; endproperty
  a_items: assert property (p_items) else $error("too many items");
  // No record is written while the store is full.
  property p_full; hist_req |-> !log_full; endproperty
  a_full: assert property (p_full) else $error("record while full");
  // The cause stays put between records.
  property p_hold; !hist_req |-> $stable(hist_cause); endproperty
  a_hold: assert property (p_hold) else $error("cause moved without record");
endmodule
bind rlel_top rlel_chk rlel_chk_i (.clk, .resetn, .hreadyout, .hresp,
  .rms_valid, .cap_done, .cap_start, .cap_waves, .cap_points, .relay_set, .relay_com_no,
  .relay_com_nc, .hist_req, .hist_cause, .hist_items, .log_full);

// ==== rlel_eng.sv ====
// Measurement engine model that finishes each requested capture.
// Assumes the capture request is a one-cycle pulse on clk.
`timescale 1ns/1ps
module rlel_eng (
  // Clock and capture handshake.
  input  wire logic clk,
  input  wire logic cap_start,
  output logic      cap_done
);
  logic [2:0] left_q = 3'h0;
  initial cap_done = 1'b0;
  // Reports a capture done five cycles after its request.
  always @(posedge clk) begin
    left_q <= cap_start ? 3'h4 : (left_q != 3'h0 ? left_q - 3'h1 : 3'h0);
    cap_done <= (left_q == 3'h1);
  end
endmodule

// ==== relay_limit_logic_event_logger_test.sv ====
// Testbench of the relay and logger block.
// Assumes rlel_top, its checker and the engine model are compiled first.
`timescale 1ns/1ps
module relay_limit_logic_event_logger_test;
  localparam int TC = 20;
  logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, rms_valid = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
  logic [1:0] htrans = 0;
  logic [15:0] lim_exc = 0;
  logic [2:0][13:0] rms = 0;
  logic hreadyout, hresp, cap_done, cap_start, hist_req, log_full;
  logic [2:0] relay_set, com_no, com_nc, cap_waves;
  logic [9:0] cap_points;
  logic [5:0] hist_items;
  rlel_pkg::rlel_cause_t hist_cause;
  int failures = 0, num_checks = 0, ncap = 0, nhist = 0;
  // Clock of 5 ns.
  always #2.5 clk = ~clk;
  // Counts capture and record requests.
  always @(posedge clk) begin
    ncap <= ncap + (cap_start === 1'b1);
    nhist <= nhist + (hist_req === 1'b1);
  end
  rlel_top #(.TICK_CYC(TC)) rlel_top_i (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .lim_exc,
    .rms_valid, .rms_v(rms), .rms_i(rms), .cap_done, .din(4'h0), .relay_set,
    .relay_com_no(com_no), .relay_com_nc(com_nc), .cap_start, .cap_waves, .cap_points,
    .cap_stamp(), .hist_req, .hist_cause, .hist_stamp(), .hist_items, .log_full);
  rlel_eng rlel_eng_i (.clk, .cap_start, .cap_done);
  task ck(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %0t got %h want %h", $time, s, e);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One single AHB-Lite word transfer; read data lands in rd.
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rms_in(input logic [13:0] v);
    @(posedge clk);
    rms <= {3{v}}; rms_valid <= 1'b1;
    @(posedge clk);
    rms_valid <= 1'b0;
  endtask
  task t_regs;
    bus(0, 32'h0, 32'h0); ck(rd, 32'h0001_3704);
    bus(0, 32'h4, 32'h0); ck(rd, 32'h0000_0384);
    bus(0, 32'h80, 32'h0); ck(rd, 32'h0);
    $display("regs done");
  endtask
  task t_delay;
    bus(1, 32'h30, 32'h1); bus(1, 32'h34, 32'h0001_0002);
    lim_exc[0] <= 1'b1; wt(15); lim_exc[0] <= 1'b0; wt(10); lim_exc[0] <= 1'b1; wt(15);
    ck(relay_set[0], 1'b0);
    wt(32); ck(relay_set[0], 1'b1);
    ck({com_no[0], com_nc[0]}, 2'b10);
    bus(1, 32'h30, 32'h0800_0001); wt(2); ck({com_no[0], com_nc[0]}, 2'b01);
    $display("delay done");
  endtask
  task t_and;
    bus(1, 32'h38, 32'h0100_0006);
    lim_exc[2:1] <= 2'b01; wt(4); ck(relay_set[1], 1'b0);
    lim_exc[2:1] <= 2'b11; wt(4); ck(relay_set[1], 1'b1);
    $display("and done");
  endtask
  task t_comp;
    bus(1, 32'h44, 32'hffff_0000); bus(1, 32'h48, 32'h44); wt(3);
    ck(relay_set[2], 1'b0);
    bus(1, 32'h40, 32'h0400_0000); bus(1, 32'h48, 32'h44); wt(3);
    ck(relay_set, 3'h7);
    $display("comp done");
  endtask
  task t_wave;
    bus(1, 32'h1c, 32'h4064); bus(1, 32'h0, 32'h0002_370c);
    rms_in(14'd200); rms_in(14'd0); wt(30); ck(ncap, 2);
    ck({cap_waves, cap_points}, {3'h6, 10'h3c0});
    bus(1, 32'h0, 32'h0003_3704); rms_in(14'd200); rms_in(14'd0); wt(30);
    ck(ncap, 3);
    bus(1, 32'h1c, 32'h670f); rms_in(14'h3fff); wt(10); ck(ncap, 3);
    $display("wave done");
  endtask
  // Records are two ticks apart; the tick phase is free, so sync on the second record.
  task t_log;
    bus(1, 32'h4, 32'h2); bus(1, 32'h0, 32'h0001_3705); wt(4);
    ck(nhist, 1);
    ck({hist_cause.interval, hist_items}, {1'b1, 6'h37});
    for (int i = 0; i < 2 * TC + 4 && nhist < 2; i++) wt(1);
    wt(2 * TC - 3); ck(nhist, 2);
    wt(6); ck(nhist, 3);
    $display("log done");
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset for six cycles, then the tests in turn.
  initial begin
    wt(6); resetn <= 1'b1;
    t_regs; t_delay; t_and; t_comp; t_wave; t_log;
    end_of_test;
  end
  // Cuts a hung run short.
  initial begin
    #40000;
    failures++;
    end_of_test;
  end
endmodule
